// ==== design/zcd_consts.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * zero-cross detector control block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef ZCD_CONSTS_SVH
`define ZCD_CONSTS_SVH

`define ZCD_ADDR_W          2
`define ZCD_DATA_W          8
`define ZCD_OFF_CONTROL_A   2'h0
`define ZCD_OFF_RESERVED    2'h1
`define ZCD_OFF_INT_CONTROL 2'h2
`define ZCD_OFF_STATUS      2'h3
`define ZCD_OFF_IRQ_MASK    2'h1
`define ZCD_RST_VALUE       8'h00
`define ZCD_BIT_ENABLE      0
`define ZCD_BIT_INVERT      3
`define ZCD_BIT_OUT_EN      6
`define ZCD_BIT_RUN_STDBY   7
`define ZCD_BIT_CROSS       0
`define ZCD_BIT_STATE       4
`define ZCD_MODE_LSB        0
`define ZCD_SYNC_STAGES     3

`endif

// ==== design/zcd_pkg.sv ====
/*
 * Types shared by the zero-cross detector control block.
 * Assumes nothing of its surroundings.
 */
package zcd_pkg;

   typedef enum logic [1:0] {
      ZCD_EDGE_NONE    = 2'b00,
      ZCD_EDGE_RISING  = 2'b01,
      ZCD_EDGE_FALLING = 2'b10,
      ZCD_EDGE_BOTH    = 2'b11
   } zcd_edge_type;

   typedef enum logic [1:0] {
      ZCD_PWR_ACTIVE    = 2'b00,
      ZCD_PWR_IDLE      = 2'b01,
      ZCD_PWR_STANDBY   = 2'b10,
      ZCD_PWR_POWERDOWN = 2'b11
   } zcd_sleep_type;

   typedef struct packed {
      logic                    wr;
      logic                    rd;
      logic [1:0]              addr;
      logic [7:0]              wdata;
   } zcd_bus_req_type;

endpackage

// ==== design/zcd_sync.sv ====
/*
 * Multi-stage level synchroniser with a parameterised depth.
 * Assumes an active-low asynchronous reset already synchronised by the caller.
 */
`timescale 1ns/1ps
module zcd_sync #(
   parameter int STAGES = 3
) (
   input  wire logic clk,     // Clock
   input  wire logic rst_n,   // Reset, active low
   input  wire logic din,     // Level to carry across
   output logic      dout     // Synchronised level
);
   typedef struct packed {
      logic [STAGES-1:0] chain;
   } zcd_sync_state_type;

   zcd_sync_state_type s_q;
   zcd_sync_state_type s_d;

   always_comb begin
      s_d = s_q;
      s_d.chain = {s_q.chain[STAGES-2:0], din};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.chain[STAGES-1];
endmodule

// ==== design/zcd_edge.sv ====
/*
 * Edge finder on a synchronised level, filtered by the selected edge mode.
 * Assumes its input is already in the clock domain.
 */
`timescale 1ns/1ps
module zcd_edge (
   input  wire logic                  clk,      // Clock
   input  wire logic                  rst_n,    // Reset, active low
   input  wire logic                  level,    // Synchronised output level
   input  wire logic                  active,   // Detection allowed
   input  wire zcd_pkg::zcd_edge_type mode,     // Selected edges
   output logic                       hit       // One-cycle pulse on a chosen edge
);
   import zcd_pkg::*;

   typedef struct packed {
      logic prev;
   } zcd_edge_state_type;

   zcd_edge_state_type s_q;
   zcd_edge_state_type s_d;
   logic               rise;
   logic               fall;

   always_comb begin
      s_d = s_q;
      s_d.prev = active ? level : 1'b0;
      rise = active && level && !s_q.prev;
      fall = active && !level && s_q.prev;
      case (mode)
         ZCD_EDGE_NONE:    hit = 1'b0;
         ZCD_EDGE_RISING:  hit = rise;
         ZCD_EDGE_FALLING: hit = fall;
         ZCD_EDGE_BOTH:    hit = rise | fall;
         default:          hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ==== design/zcd_ctrl.sv ====
/*
 * Control and status logic of the zero-cross detector: register port,
 * output inversion and pin routing, synchronised state, edge flag, interrupt.
 * Assumes the comparator result is a level synchronous to clk and that the
 * power manager reports the sleep mode as a level.
 */
// Strobed register access is this design's own decision.
// Notes on behaviour
// [RL1] Run-in-standby keeps detector alive in standby
// [RL2] Pin output driven only with pin enable
// [RL3] Invert bit inverts the comparator result
// [RL4] Enable bit activates the detector
// [RL5] Edge select: none, rising, falling, both
// [RL6] State bit shows output after three-stage synchroniser
// [RL7] Crossing flag cleared by writing one
// [RL8] Fixed offsets, all registers reset zero
// [RL9] Matching edge of inverted output sets flag
// [RL10] Interrupt while mode not none and flag; the code also requires irq_mask clear
// [RL11] Output level given as event, no inputs
// [RL12] Inactive in power-down, standby unless run-in-standby
// [RL13] Disabled detector holds output and detection off
// [RL14] Edges found on synchronised samples
`timescale 1ns/1ps
`include "zcd_consts.svh"
module zcd_ctrl (
   input  wire logic                  clk,          // Peripheral clock
   input  wire logic                  rst_n,        // Reset, active low
   input  wire logic [1:0]            addr,         // Register offset
   input  wire logic [7:0]            wdata,        // Write data
   input  wire logic                  wr,           // Write strobe
   input  wire logic                  rd,           // Read strobe
   output logic      [7:0]            rdata,        // Read data, cycle after rd
   input  wire logic                  comp_in,      // Analog comparator result
   input  wire zcd_pkg::zcd_sleep_type sleep_mode,  // Current sleep mode
   output logic                       pin_out,      // Detector output to pin
   output logic                       pin_oe,       // Pin driven
   output logic                       event_out,    // Output level event
   output logic                       irq           // Interrupt request
);
   import zcd_pkg::*;

   typedef struct packed {
      logic [7:0]   control_a;
      zcd_edge_type edge_select;
      logic         crossing_flag;
      logic         irq_mask;
      logic [7:0]   rdata;
      logic         pin_out;
      logic         pin_oe;
      logic         event_out;
      logic         irq;
   } zcd_state_type;

   zcd_state_type s_q;
   zcd_state_type s_d;
   logic [1:0]    rst_sync_q;
   logic          rst_int_n;
   logic          active;
   logic          det_out;
   logic          state_sync;
   logic          edge_hit;

   // Decode of a write to one register
   function automatic logic wr_hit(input logic w, input logic [1:0] a, input logic [1:0] off);
      wr_hit = w && (a == off);
   endfunction

   assign rst_int_n = rst_sync_q[1];

   // Reset release copy, kept apart: it cannot share the reset it makes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   // [RL4] [RL1] [RL12] activity gate
   always_comb begin
      case (sleep_mode)
         ZCD_PWR_ACTIVE:    active = s_q.control_a[`ZCD_BIT_ENABLE];
         ZCD_PWR_IDLE:      active = s_q.control_a[`ZCD_BIT_ENABLE];
         ZCD_PWR_STANDBY:   active = s_q.control_a[`ZCD_BIT_ENABLE] && s_q.control_a[`ZCD_BIT_RUN_STDBY];
         ZCD_PWR_POWERDOWN: active = 1'b0;
         default:           active = 1'b0;
      endcase
   end

   // [RL3] [RL13] inverted, gated output
   assign det_out = active && (comp_in ^ s_q.control_a[`ZCD_BIT_INVERT]);

   // [RL6] three-stage state synchroniser
   zcd_sync #(
      .STAGES (`ZCD_SYNC_STAGES)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_int_n),
      .din   (det_out),
      .dout  (state_sync)
   );

   // [RL14] [RL5] edge detection on samples
   zcd_edge u_edge (
      .clk    (clk),
      .rst_n  (rst_int_n),
      .level  (state_sync),
      .active (active),
      .mode   (s_q.edge_select),
      .hit    (edge_hit)
   );

   always_comb begin
      s_d = s_q;

      if (wr_hit(wr, addr, `ZCD_OFF_CONTROL_A)) begin
         s_d.control_a = wdata & 8'hc9;
      end
      if (wr_hit(wr, addr, `ZCD_OFF_INT_CONTROL)) begin
         s_d.edge_select = zcd_edge_type'(wdata[`ZCD_MODE_LSB +: 2]);
      end
      if (wr_hit(wr, addr, `ZCD_OFF_IRQ_MASK)) begin
         s_d.irq_mask = wdata[0];
      end

      // [RL7] write one clears flag
      if (wr_hit(wr, addr, `ZCD_OFF_STATUS) && wdata[`ZCD_BIT_CROSS]) begin
         s_d.crossing_flag = 1'b0;
      end
      // [RL9] matching edge sets flag, set wins
      if (edge_hit) begin
         s_d.crossing_flag = 1'b1;
      end

      // [RL8] register read map
      s_d.rdata = 8'h00;
      if (rd) begin
         case (addr)
            `ZCD_OFF_CONTROL_A:   s_d.rdata = s_q.control_a;
            `ZCD_OFF_IRQ_MASK:    s_d.rdata = {7'h00, s_q.irq_mask};
            `ZCD_OFF_INT_CONTROL: s_d.rdata = {6'h00, s_q.edge_select};
            `ZCD_OFF_STATUS: begin
               s_d.rdata[`ZCD_BIT_STATE] = active && state_sync;
               s_d.rdata[`ZCD_BIT_CROSS] = s_q.crossing_flag;
            end
            default:              s_d.rdata = 8'h00;
         endcase
      end

      // [RL2] pin routing with enable
      s_d.pin_oe  = active && s_q.control_a[`ZCD_BIT_OUT_EN];
      s_d.pin_out = active && s_q.control_a[`ZCD_BIT_OUT_EN] && det_out;
      // [RL11] level event follows output
      s_d.event_out = det_out;
      // [RL10] interrupt while flag and mode and irq_mask clear
      s_d.irq = s_d.crossing_flag && (s_d.edge_select != ZCD_EDGE_NONE) && !s_d.irq_mask;
   end

   always_ff @(posedge clk or negedge rst_int_n) begin
      if (!rst_int_n) begin
         s_q.control_a     <= `ZCD_RST_VALUE;
         s_q.edge_select   <= ZCD_EDGE_NONE;
         s_q.crossing_flag <= 1'b0;
         s_q.irq_mask      <= 1'b0;
         s_q.rdata         <= 8'h00;
         s_q.pin_out       <= 1'b0;
         s_q.pin_oe        <= 1'b0;
         s_q.event_out     <= 1'b0;
         s_q.irq           <= 1'b0;
      end else begin
         s_q.control_a     <= s_d.control_a;
         s_q.edge_select   <= s_d.edge_select;
         s_q.crossing_flag <= s_d.crossing_flag;
         s_q.irq_mask      <= s_d.irq_mask;
         s_q.rdata         <= s_d.rdata;
         s_q.pin_out       <= s_d.pin_out;
         s_q.pin_oe        <= s_d.pin_oe;
         s_q.event_out     <= s_d.event_out;
         s_q.irq           <= s_d.irq;
      end
   end

   assign rdata     = s_q.rdata;
   assign pin_out   = s_q.pin_out;
   assign pin_oe    = s_q.pin_oe;
   assign event_out = s_q.event_out;
   assign irq       = s_q.irq;
endmodule

// ==== sim/zcd_comp_model.sv ====
/* Comparator stand-in: comp_in follows a requested level DLY clocks later.
   Assumes the bench changes level just after rising edges. */
`timescale 1ns/1ps
module zcd_comp_model #(
   parameter int DLY = 2
) (
   input  wire logic clk,     // Clock
   input  wire logic level,   // Requested level
   output logic      comp_in  // Comparator result
);
   logic [DLY-1:0] pipe_q = '0;
   always @(posedge clk) begin
      pipe_q <= {pipe_q[DLY-2:0], level};
   end
   assign comp_in = pipe_q[DLY-1];
endmodule

// ==== sim/zcd_ctrl_props.sv ====
/* Port-level checker of zcd_ctrl.
   Bound from the bench top; shadows the writable registers. */
`timescale 1ns/1ps
module zcd_ctrl_props (
   input wire logic                   clk,        // Clock
   input wire logic                   rst_n,      // Reset
   input wire logic [1:0]             addr,       // Offset
   input wire logic [7:0]             wdata,      // Write data
   input wire logic                   wr,         // Write
   input wire logic                   rd,         // Read
   input wire logic [7:0]             rdata,      // Read data
   input wire logic                   comp_in,    // Comparator
   input wire zcd_pkg::zcd_sleep_type sleep_mode, // Sleep
   input wire logic                   pin_out,    // Pin
   input wire logic                   pin_oe,     // Pin driven
   input wire logic                   event_out,  // Event
   input wire logic                   irq         // Interrupt
);
   import zcd_pkg::*;
   logic [7:0] ctl_q;
   logic [1:0] mode_q;
   logic       mask_q;
   logic       act;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_q <= 8'h00;
         mode_q <= 2'h0;
         mask_q <= 1'b0;
      end else if (wr) begin
         if (addr == 2'h0) ctl_q <= wdata;
         if (addr == 2'h1) mask_q <= wdata[0];
         if (addr == 2'h2) mode_q <= wdata[1:0];
      end
   end
   assign act = ctl_q[0] && sleep_mode != ZCD_PWR_POWERDOWN && (sleep_mode != ZCD_PWR_STANDBY || ctl_q[7]);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // The edge reaches the flag logic two cycles after the event output, judged by the mode then
   sequence s_rise; $rose(event_out) && act ##2 act && mode_q[0] && !mask_q; endsequence
   sequence s_fall; $fell(event_out) && act ##2 act && mode_q[1] && !mask_q; endsequence
   chk_event_level: assert property (event_out == $past(act && (comp_in ^ ctl_q[3])))
      else $error("event level wrong");
   chk_pin_enable: assert property (pin_oe == $past(act && ctl_q[6]))
      else $error("pin enable wrong");
   chk_pin_level: assert property (pin_oe |-> pin_out == event_out)
      else $error("pin level wrong");
   chk_rise_flag: assert property (s_rise |=> irq)
      else $error("rising edge missed");
   chk_fall_flag: assert property (s_fall |=> irq)
      else $error("falling edge missed");
   chk_irq_cause: assert property ($rose(irq) |-> mode_q != 2'h0 && !mask_q)
      else $error("irq without cause");
   chk_zero_keeps: assert property (irq && wr && addr == 2'h3 && !wdata[0] |=> irq)
      else $error("zero write cleared flag");
   chk_rd_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read");
   chk_ctl_read: assert property ($past(rd && addr == 2'h0) |-> rdata == ($past(ctl_q) & 8'hc9))
      else $error("control read wrong");
   chk_state_read: assert property ($past(rd && addr == 2'h3)
      |-> rdata[4] == ($past(event_out, 3) && $past(act)))
      else $error("state bit wrong");
endmodule

// ==== sim/zcd_ctrl_test.sv ====
/* Self-checking bench of zcd_ctrl with a comparator model.
   Assumes the design and checker files are compiled first. */
`timescale 1ns/1ps
module zcd_ctrl_test;
   import zcd_pkg::*;
   logic          clk = 1'b0, rst_n, wr, rd, lvl;
   logic [1:0]    addr;
   logic [7:0]    wdata, rdata;
   logic          comp_in, pin_out, pin_oe, event_out, irq;
   zcd_sleep_type sleep_mode;
   int            err_count, checks_done;
   zcd_comp_model #(.DLY(2)) cmp (.clk(clk), .level(lvl), .comp_in(comp_in));
   zcd_ctrl uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .comp_in(comp_in), .sleep_mode(sleep_mode), .pin_out(pin_out),
      .pin_oe(pin_oe), .event_out(event_out), .irq(irq));
   always #20 clk = ~clk;
   task test_done;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
      @(posedge clk) wr <= 1'b0;
   endtask
   task rreg(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk) {rd, addr} <= {1'b1, a};
      @(posedge clk) rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task setl(input logic v);
      @(posedge clk) lvl <= v;
      step(8);
   endtask
   task t_regs;
      for (int a = 0; a < 4; a++) rreg(2'(a), 8'h00);
      wreg(2'h2, 8'hff);
      rreg(2'h2, 8'h03);
      wreg(2'h2, 8'h00);
      wreg(2'h0, 8'hff);
      rreg(2'h0, 8'hc9);
      wreg(2'h0, 8'h00);
      wreg(2'h3, 8'hff);
      step(4);
      rreg(2'h3, 8'h00);
   endtask
   task t_modes;
      logic [1:0] m;
      logic       inv;
      for (int k = 0; k < 8; k++) begin
         {inv, m} = 3'(k);
         wreg(2'h0, {4'h0, inv, 3'h1});
         wreg(2'h2, {6'h0, m});
         setl(1'b0);
         wreg(2'h3, 8'h01);
         setl(1'b1);
         chk(8'(event_out), 8'(!inv));
         rreg(2'h3, {3'h0, !inv, 3'h0, inv ? m[1] : m[0]});
         chk(8'(irq), 8'(inv ? m[1] : m[0]));
         wreg(2'h3, 8'h01);
         setl(1'b0);
         chk(8'(irq), 8'(inv ? m[0] : m[1]));
      end
   endtask
   task t_clear;
      wreg(2'h0, 8'h01);
      wreg(2'h2, 8'h01);
      wreg(2'h3, 8'h01);
      setl(1'b1);
      wreg(2'h3, 8'h00);
      step(2);
      chk(8'(irq), 8'h01);
      wreg(2'h1, 8'h01);
      step(2);
      chk(8'(irq), 8'h00);
      wreg(2'h1, 8'h00);
      step(2);
      chk(8'(irq), 8'h01);
      wreg(2'h3, 8'h01);
      step(2);
      chk(8'(irq), 8'h00);
      wreg(2'h2, 8'h00);
   endtask
   task t_pin_sleep;
      wreg(2'h0, 8'h41);
      step(2);
      chk(8'({pin_oe, pin_out}), 8'h03);
      wreg(2'h0, 8'h01);
      step(2);
      chk(8'(pin_oe), 8'h00);
      @(posedge clk) sleep_mode <= ZCD_PWR_STANDBY;
      step(3);
      chk(8'(event_out), 8'h00);
      wreg(2'h0, 8'h81);
      step(3);
      chk(8'(event_out), 8'h01);
      @(posedge clk) sleep_mode <= ZCD_PWR_POWERDOWN;
      step(3);
      chk(8'(event_out), 8'h00);
      @(posedge clk) sleep_mode <= ZCD_PWR_IDLE;
      step(3);
      chk(8'(event_out), 8'h01);
      @(posedge clk) sleep_mode <= ZCD_PWR_ACTIVE;
      wreg(2'h0, 8'h00);
      wreg(2'h2, 8'h03);
      setl(1'b0);
      setl(1'b1);
      chk(8'({irq, event_out}), 8'h00);
      rreg(2'h3, 8'h00);
   endtask
   // Mid-run reset with a flag pending and the pin driven
   task t_reset;
      wreg(2'h0, 8'h41);
      step(6);
      chk(8'({pin_oe, pin_out, irq}), 8'h07);
      @(posedge clk) rst_n <= 1'b0;
      step(2);
      chk(8'({pin_oe, pin_out, event_out, irq}), 8'h00);
      @(posedge clk) rst_n <= 1'b1;
      step(3);
      for (int a = 0; a < 4; a++) rreg(2'(a), 8'h00);
      chk(8'({pin_oe, event_out, irq}), 8'h00);
   endtask
   initial begin
      {rst_n, wr, rd, lvl, addr, wdata} = '0;
      sleep_mode = ZCD_PWR_ACTIVE;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      step(3);
      t_regs;
      t_modes;
      t_clear;
      t_pin_sleep;
      t_reset;
      test_done;
   end
   initial begin
      #1ms;
      err_count++;
      test_done;
   end
endmodule
bind zcd_ctrl zcd_ctrl_props chk_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .comp_in(comp_in), .sleep_mode(sleep_mode), .pin_out(pin_out),
   .pin_oe(pin_oe), .event_out(event_out), .irq(irq));
